/* core/adc_link_pkg.sv */
// What this block does
// - produce a 12-bit result every conversion cycle
// - link clock doubles as conversion clock
// - host keeps the link clock at most 20 MHz
// - output stays undriven until select falls, or sync falls with select low
// - result leaves most significant bit first
// - sync high at select fall: select starts
// - sync low at select fall: select fall still starts frame
// - in dsp mode host marks frame start with falling sync
// - unused sync input held permanently high
// - dedicated port: select low, sync delimits frames
// - idle device powers down by itself
// - 16-bit frame: result then four pad bits
// - output bit changes on rising link clock
// - output released after sixteenth clock
// - sample clocks 5 to 16, then convert
package adc_link_pkg;
  localparam int     RESULT_W      = 12;
  localparam int     FRAME_BITS    = 16;
  localparam int     SAMPLE_FIRST  = 5;
  localparam int     SAMPLE_CLKS   = 12;
  localparam int     SAMPLE_LAST   = SAMPLE_FIRST + SAMPLE_CLKS - 1;
  localparam int     CNT_W         = 6;
  localparam int     LINK_RST_CYC  = 32;
  localparam longint SCLK_MAX_HZ   = 20_000_000;
  localparam longint SYS_CLK_HZ    = 125_000_000;
  localparam longint CONV_TIME_NS  = 1400;
  localparam longint CONV_OVH_NS   = 100;
  localparam int     CONV_CLKS     =
    int'(((CONV_TIME_NS + CONV_OVH_NS) * SCLK_MAX_HZ + 999_999_999) / 1_000_000_000);
  localparam int     SCLK_HALF_CYC =
    int'((SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ));
  localparam int     FIFO_DEPTH    = 32;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  typedef enum logic [1:0] {dev_sleep, dev_frame, dev_convert} dev_state_t;
  typedef enum logic [1:0] {h_idle, h_frame, h_conv, h_gap} host_state_t;
endpackage : adc_link_pkg

/* core/adc_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface adc_link_if;
  logic link_clk;
  logic dev_sel_n;
  logic frame_sync;
  logic serial_result_out;
  logic serial_result_oe;
  wire  serial_result_line;

  // released line shows inverted data so a late sample stands out
  assign serial_result_line = serial_result_oe ? serial_result_out : ~serial_result_out;

  modport dev (
    input  link_clk,
    input  dev_sel_n,
    input  frame_sync,
    output serial_result_out,
    output serial_result_oe
  );

  modport host (
    output link_clk,
    output dev_sel_n,
    output frame_sync,
    input  serial_result_line
  );
endinterface : adc_link_if
`default_nettype wire

/* core/adc_dev_end.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_dev_end
  import adc_link_pkg::*;
#(
  parameter int RES_W  = RESULT_W,
  parameter int CONV_N = CONV_CLKS
) (
  input  wire logic             sys_clk_in,       // user-side clock
  input  wire logic             rst_n_in,         // sync reset, active low
  input  wire logic [RES_W-1:0] analog_input_in,  // digitised input level
  output logic      [RES_W-1:0] result_out,       // last finished result
  output logic                  result_valid_out, // pulse: new result
  output logic                  power_down_out,   // high while powered down
  adc_link_if.dev               link              // serial link, device end
);

  localparam int PAD_N = FRAME_BITS - RES_W;

  // link clock domain
  logic                  rst_meta_r;
  logic                  rst_sync_r;
  logic [RES_W-1:0]      ain_meta_r;
  logic [RES_W-1:0]      ain_sync_r;
  logic                  sel_q_r;
  logic                  sync_q_r;
  dev_state_t            state_r;
  logic [CNT_W-1:0]      edge_cnt_r;
  logic [CNT_W-1:0]      conv_cnt_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic                  sdo_r;
  logic                  oe_r;
  logic [RES_W-1:0]      hold_r;
  logic [RES_W-1:0]      sar_r;
  logic [RES_W-1:0]      mask_r;
  logic [RES_W-1:0]      result_r;
  logic                  res_tgl_r;
  logic                  pd_r;

  // user clock domain
  logic                  tgl_meta_r;
  logic                  tgl_sync_r;
  logic                  tgl_seen_r;
  logic                  pd_meta_r;
  logic [CNT_W-1:0]      rst_cnt_r;
  logic                  link_rst_n_r;

  logic                  frame_start;
  logic                  sel_rise;
  logic                  last_edge;
  logic                  conv_done;
  logic [CNT_W-1:0]      edge_nxt;

  // link clock stands still in reset, so stretch it past release
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rst_cnt_r    <= '0;
      link_rst_n_r <= 1'b0;
    end else if (rst_cnt_r != CNT_W'(LINK_RST_CYC)) begin
      rst_cnt_r <= rst_cnt_r + 1'b1;
    end else begin
      link_rst_n_r <= 1'b1;
    end
  end

  // link-domain reset release
  always_ff @(posedge link.link_clk) begin
    rst_meta_r <= link_rst_n_r;
    rst_sync_r <= rst_meta_r;
  end

  // input level comes from outside the link domain
  always_ff @(posedge link.link_clk) begin
    ain_meta_r <= analog_input_in;
    ain_sync_r <= ain_meta_r;
  end

  // select and sync are launched on the link clock
  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      sel_q_r  <= 1'b1;
      sync_q_r <= 1'b1;
    end else begin
      sel_q_r  <= link.dev_sel_n;
      sync_q_r <= link.frame_sync;
    end
  end

  assign frame_start = (sel_q_r & ~link.dev_sel_n)
                     | (sync_q_r & ~link.frame_sync & ~link.dev_sel_n);
  assign sel_rise    = ~sel_q_r & link.dev_sel_n;
  assign edge_nxt    = edge_cnt_r + 1'b1;
  assign last_edge   = (state_r == dev_frame) && (edge_cnt_r == CNT_W'(FRAME_BITS - 1));
  assign conv_done   = (state_r == dev_convert) && (conv_cnt_r == CNT_W'(CONV_N - 1));

  // sleeps whenever no frame or conversion runs
  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      state_r <= dev_sleep;
    end else if (frame_start) begin
      state_r <= dev_frame;
    end else begin
      unique case (state_r)
        dev_sleep: begin
          state_r <= dev_sleep;
        end
        dev_frame: begin
          if (sel_rise) begin
            state_r <= dev_sleep;
          end else if (last_edge) begin
            state_r <= dev_convert;
          end
        end
        dev_convert: begin
          // early select rise abandons the conversion
          if (sel_rise || conv_done) begin
            state_r <= dev_sleep;
          end
        end
        default: begin
          state_r <= dev_sleep;
        end
      endcase
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      edge_cnt_r <= '0;
    end else if (frame_start) begin
      edge_cnt_r <= '0;
    end else if (state_r == dev_frame) begin
      edge_cnt_r <= edge_nxt;
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      shift_r <= '0;
      sdo_r   <= 1'b0;
    end else if (frame_start) begin
      shift_r <= {result_r, {PAD_N{1'b0}}};
      sdo_r   <= result_r[RES_W-1];
    end else if (state_r == dev_frame) begin
      shift_r <= shift_r << 1;
      sdo_r   <= shift_r[FRAME_BITS-2];
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      oe_r <= 1'b0;
    end else if (frame_start) begin
      oe_r <= 1'b1;
    end else if (link.dev_sel_n || last_edge || state_r != dev_frame) begin
      oe_r <= 1'b0;
    end
  end

  // track during clocks 5 to 16, hold after
  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      hold_r <= '0;
    end else if (state_r == dev_frame && !frame_start
                 && edge_nxt >= CNT_W'(SAMPLE_FIRST)
                 && edge_nxt <= CNT_W'(SAMPLE_LAST)) begin
      hold_r <= ain_sync_r;
    end
  end

  // conversion timed by link clock edges
  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      conv_cnt_r <= '0;
    end else if (state_r == dev_frame) begin
      conv_cnt_r <= '0;
    end else if (state_r == dev_convert) begin
      conv_cnt_r <= conv_cnt_r + 1'b1;
    end
  end

  // successive approximation, one bit per edge
  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      sar_r  <= '0;
      mask_r <= '0;
    end else if (last_edge) begin
      sar_r  <= '0;
      mask_r <= {1'b1, {(RES_W-1){1'b0}}};
    end else if (state_r == dev_convert && mask_r != '0) begin
      if ((sar_r | mask_r) <= hold_r) begin
        sar_r <= sar_r | mask_r;
      end
      mask_r <= mask_r >> 1;
    end
  end

  // publish result at end of conversion
  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      result_r  <= RESULT_RST;
      res_tgl_r <= 1'b0;
    end else if (conv_done && !sel_rise && !frame_start) begin
      result_r  <= sar_r;
      res_tgl_r <= ~res_tgl_r;
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_sync_r) begin
      pd_r <= 1'b1;
    end else begin
      pd_r <= (state_r == dev_sleep);
    end
  end

  assign link.serial_result_out = sdo_r;
  assign link.serial_result_oe  = oe_r;

  // result toggle into the user domain
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= res_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  // word is stable for many link edges after the toggle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      result_out       <= RESULT_RST;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= tgl_sync_r ^ tgl_seen_r;
      if (tgl_sync_r ^ tgl_seen_r) begin
        result_out <= result_r;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pd_meta_r      <= 1'b1;
      power_down_out <= 1'b1;
    end else begin
      pd_meta_r      <= pd_r;
      power_down_out <= pd_meta_r;
    end
  end

endmodule : adc_dev_end
`default_nettype wire

/* core/adc_host_end.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_result_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_in,       // clock
  input  wire logic         rst_n_in,     // sync reset, active low
  input  wire logic         in_valid_in,  // write request
  output logic              in_ready_out, // room for a word
  input  wire logic [W-1:0] in_data_in,   // write data
  output logic              out_valid_out,// word available
  input  wire logic         out_ready_in, // reader takes word
  output logic [W-1:0]      out_data_out  // oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : adc_result_fifo

module adc_host_end
  import adc_link_pkg::*;
(
  input  wire logic           sys_clk_in,       // system clock
  input  wire logic           rst_n_in,         // sync reset, active low
  input  wire logic           run_in,           // keep converting
  input  wire logic           dsp_mode_in,      // 1: sync framing, 0: select framing
  output logic [RESULT_W-1:0] result_data_out,  // fifo head
  output logic                result_valid_out, // fifo not empty
  input  wire logic           result_ready_in,  // consumer takes head
  output logic                busy_out,         // frame or wait in progress
  adc_link_if.host            link              // serial link, host end
);
  localparam int DIV_W = $clog2(SCLK_HALF_CYC + 1);

  logic [DIV_W-1:0]      div_cnt_r;
  logic                  sclk_r;
  logic                  sel_n_r;
  logic                  sync_r;
  logic                  sdo_meta_r;
  logic                  sdo_sync_r;
  host_state_t           state_r;
  logic [CNT_W-1:0]      cnt_r;
  logic                  mode_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic                  push_r;
  logic [RESULT_W-1:0]   push_data_r;
  logic                  fifo_ready;
  logic                  div_wrap;
  logic                  fall_evt;
  logic [FRAME_BITS-1:0] word;

  assign div_wrap = (div_cnt_r == DIV_W'(SCLK_HALF_CYC - 1));
  assign fall_evt = div_wrap & sclk_r;
  assign word     = {shift_r[FRAME_BITS-2:0], sdo_sync_r};

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= '0;
      sclk_r    <= 1'b0;
    end else if (div_wrap) begin
      div_cnt_r <= '0;
      sclk_r    <= ~sclk_r;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    sdo_meta_r <= link.serial_result_line;
    sdo_sync_r <= sdo_meta_r;
  end

  // frame sequencing, changes on falling link clock
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= h_idle;
      cnt_r   <= '0;
      mode_r  <= 1'b0;
      sel_n_r <= 1'b1;
      sync_r  <= 1'b1;
      shift_r <= '0;
    end else if (fall_evt) begin
      unique case (state_r)
        h_idle: begin
          sel_n_r <= ~dsp_mode_in;
          // frame waits for fifo room
          if (run_in && fifo_ready) begin
            state_r <= h_frame;
            cnt_r   <= '0;
            mode_r  <= dsp_mode_in;
            sel_n_r <= 1'b0;
            // sync falls only in dsp mode
            sync_r  <= ~dsp_mode_in;
          end
        end
        h_frame: begin
          sync_r  <= 1'b1;
          shift_r <= word;
          cnt_r   <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(FRAME_BITS - 1)) begin
            state_r <= h_conv;
            cnt_r   <= '0;
          end
        end
        h_conv: begin
          cnt_r <= cnt_r + 1'b1;
          // select held until conversion has finished
          if (cnt_r == CNT_W'(CONV_CLKS + 1)) begin
            sel_n_r <= ~mode_r;
            state_r <= h_gap;
          end
        end
        h_gap: begin
          state_r <= h_idle;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      push_r      <= 1'b0;
      push_data_r <= '0;
      busy_out    <= 1'b0;
    end else begin
      push_r   <= fall_evt && state_r == h_frame && cnt_r == CNT_W'(FRAME_BITS - 1);
      busy_out <= (state_r != h_idle);
      if (fall_evt && state_r == h_frame) begin
        push_data_r <= word[FRAME_BITS-1 -: RESULT_W];
      end
    end
  end

  assign link.link_clk   = sclk_r;
  assign link.dev_sel_n  = sel_n_r;
  assign link.frame_sync = sync_r;

  adc_result_fifo #(
    .W     (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push_r),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_data_r),
    .out_valid_out (result_valid_out),
    .out_ready_in  (result_ready_in),
    .out_data_out  (result_data_out)
  );
endmodule : adc_host_end
`default_nettype wire

/* dv/adc_link_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_link_asserts (
  input wire logic sys_clk_in,        // host clock
  input wire logic rst_n_in,          // sync reset, active low
  input wire logic link_clk,          // link clock
  input wire logic dev_sel_n,         // select, active low
  input wire logic frame_sync,        // frame sync
  input wire logic serial_result_out, // device data
  input wire logic serial_result_oe   // device drive enable
);
  logic       sel_q;
  logic       sync_q;
  logic       start_r;
  logic       fall_val_r;
  logic       start_c;
  logic [4:0] cnt_r;
  logic [5:0] arm_cnt_r;
  logic       armed;

  // link side is still in its own reset shortly after release
  assign armed = &arm_cnt_r;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      arm_cnt_r <= 6'h00;
    end else if (!armed) begin
      arm_cnt_r <= arm_cnt_r + 6'h01;
    end
  end

  // start as the device sees it on a rise
  assign start_c = !dev_sel_n && (sel_q || (sync_q && !frame_sync));

  always_ff @(posedge link_clk) begin
    sel_q  <= dev_sel_n;
    sync_q <= frame_sync;
  end

  always_ff @(posedge link_clk) begin
    start_r <= start_c;
  end

  always_ff @(negedge link_clk) begin
    fall_val_r <= serial_result_out;
  end

  // rises since start, 17 marks release
  always_ff @(posedge link_clk) begin
    if (dev_sel_n) begin
      cnt_r <= 5'h00;
    end else if (start_c) begin
      cnt_r <= 5'h01;
    end else if (cnt_r == 5'h11) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  sequence s_start;
    start_c;
  endsequence

  sequence s_high_half;
    ##1 link_clk [*3] ##1 !link_clk;
  endsequence

  sequence s_low_half;
    ##1 !link_clk [*3] ##1 link_clk;
  endsequence

  property p_drive_at_start;
    @(posedge link_clk) disable iff (!rst_n_in || !armed) s_start |=> serial_result_oe;
  endproperty
  a_drive_at_start: assert property (p_drive_at_start)
    else $error("output not driven after frame start");

  property p_frame_len;
    @(posedge link_clk) disable iff (!rst_n_in || !armed) cnt_r != 5'h00 |-> serial_result_oe == (cnt_r <= 5'h10);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("drive enable not high for exactly sixteen bits");

  property p_pad_zero;
    @(posedge link_clk) disable iff (!rst_n_in || !armed) (cnt_r >= 5'h0d && cnt_r <= 5'h10) |-> !serial_result_out;
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("pad bit not zero");

  property p_idle_hiz;
    @(posedge link_clk) disable iff (!rst_n_in || !armed) dev_sel_n |=> !serial_result_oe;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("output driven while deselected");

  property p_oe_cause;
    @(posedge link_clk) disable iff (!rst_n_in || !armed) $rose(serial_result_oe) |-> start_r;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("drive enable rose without frame start");

  property p_rise_change;
    @(posedge link_clk) disable iff (!rst_n_in || !armed) serial_result_oe |-> serial_result_out == fall_val_r;
  endproperty
  a_rise_change: assert property (p_rise_change)
    else $error("data changed while link clock low");

  property p_clk_high;
    @(posedge sys_clk_in) disable iff (!rst_n_in) $rose(link_clk) |-> s_high_half;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("link clock high half wrong");

  property p_clk_low;
    @(posedge sys_clk_in) disable iff (!rst_n_in) $fell(link_clk) |-> s_low_half;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("link clock low half wrong");

  property p_ctl_on_fall;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      ($changed(dev_sel_n) || $changed(frame_sync)) |-> $fell(link_clk);
  endproperty
  a_ctl_on_fall: assert property (p_ctl_on_fall)
    else $error("select or sync moved off a falling link edge");
endmodule : adc_link_asserts
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import adc_link_pkg::*;
  logic                sys_clk_in = 1'b0;
  logic                rst_n_in   = 1'b0;
  logic [RESULT_W-1:0] analog_input        = 12'h000;
  logic                run        = 1'b0;
  logic                dsp_mode   = 1'b0;
  logic                pop        = 1'b0;
  logic [RESULT_W-1:0] dev_result;
  logic                dev_valid;
  logic                power_down;
  logic [RESULT_W-1:0] head;
  logic                head_valid;
  logic                busy;
  int                  err_count  = 0;
  int                  n_tests    = 0;
  int                  frames     = 0;
  int                  pulses     = 0;

  adc_link_if link_if ();

  always #4 sys_clk_in = ~sys_clk_in;

  always @(posedge link_if.serial_result_oe) frames++;

  always @(posedge sys_clk_in) begin
    if (dev_valid === 1'b1) begin
      pulses++;
    end
  end

  adc_dev_end adc_dev_end_i (
    .sys_clk_in       (sys_clk_in),
    .rst_n_in         (rst_n_in),
    .analog_input_in  (analog_input),
    .result_out       (dev_result),
    .result_valid_out (dev_valid),
    .power_down_out   (power_down),
    .link             (link_if.dev)
  );

  adc_host_end adc_host_end_i (
    .sys_clk_in       (sys_clk_in),
    .rst_n_in         (rst_n_in),
    .run_in           (run),
    .dsp_mode_in      (dsp_mode),
    .result_data_out  (head),
    .result_valid_out (head_valid),
    .result_ready_in  (pop),
    .busy_out         (busy),
    .link             (link_if.host)
  );

  adc_link_asserts adc_link_asserts_i (
    .sys_clk_in        (sys_clk_in),
    .rst_n_in          (rst_n_in),
    .link_clk          (link_if.link_clk),
    .dev_sel_n         (link_if.dev_sel_n),
    .frame_sync        (link_if.frame_sync),
    .serial_result_out (link_if.serial_result_out),
    .serial_result_oe  (link_if.serial_result_oe)
  );

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_for(ref logic sig, input logic lvl, input int limit);
    int n;
    n = 0;
    while (sig !== lvl) begin
      @(posedge sys_clk_in);
      #1;
      n++;
      if (n > limit) begin
        check("wait bound", 12'h001, 12'h000);
        final_report();
      end
    end
  endtask : wait_for

  task automatic pop_word(input logic [11:0] exp);
    wait_for(head_valid, 1'b1, 2000);
    check("fifo head", head, exp);
    @(posedge sys_clk_in) pop <= 1'b1;
    @(posedge sys_clk_in) pop <= 1'b0;
    #1;
  endtask : pop_word

  task automatic stop_and_drain(input logic [11:0] exp, output int n);
    @(posedge sys_clk_in) run <= 1'b0;
    wait_for(busy, 1'b0, 4000);
    n = 0;
    while (head_valid === 1'b1 && n < 40) begin
      pop_word(exp);
      n++;
    end
  endtask : stop_and_drain

  task automatic spi_frames();
    int n;
    @(posedge sys_clk_in) begin
      analog_input      <= 12'hfff;
      dsp_mode <= 1'b0;
      run      <= 1'b1;
    end
    pop_word(12'h000);
    pop_word(12'hfff);
    check("device result", dev_result, 12'hfff);
    stop_and_drain(12'hfff, n);
    check("power down", {11'h000, power_down}, 12'h001);
  endtask : spi_frames

  task automatic dsp_frames();
    int n;
    @(posedge sys_clk_in) begin
      analog_input      <= 12'ha5c;
      dsp_mode <= 1'b1;
      run      <= 1'b1;
    end
    pop_word(12'hfff);
    pop_word(12'ha5c);
    check("select", {11'h000, link_if.dev_sel_n}, 12'h000);
    stop_and_drain(12'ha5c, n);
  endtask : dsp_frames

  task automatic fill_and_stall();
    int f0;
    int p0;
    int n;
    f0 = frames;
    p0 = pulses;
    @(posedge sys_clk_in) begin
      analog_input <= 12'h3c7;
      run <= 1'b1;
    end
    n = 0;
    while (frames - f0 < 32 && n < 30000) begin
      @(posedge sys_clk_in);
      n++;
    end
    repeat (1500) @(posedge sys_clk_in);
    check("frames while full", 12'(frames - f0), 12'h020);
    check("conversions", 12'(pulses - p0), 12'h020);
    @(posedge sys_clk_in) run <= 1'b0;
    pop_word(12'ha5c);
    stop_and_drain(12'h3c7, n);
    check("words after head", 12'(n), 12'h01f);
  endtask : fill_and_stall

  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (64) @(posedge sys_clk_in);
    #1;
    check("power down", {11'h000, power_down}, 12'h001);
    check("drive enable", {11'h000, link_if.serial_result_oe}, 12'h000);
    spi_frames();
    dsp_frames();
    fill_and_stall();
    final_report();
  end
endmodule : testbench
`default_nettype wire
